// ==== verilog/wtu_pkg.sv ====
// Package: register map, field layout, codes and counts of the watchdog
`default_nettype none

package wtu_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Register indices and byte addresses on the APB (one word each)
  localparam logic [11:0] CTRL_INDEX    = 12'h093;
  localparam logic [11:0] RESTART_INDEX = 12'h094;
  localparam logic [11:0] STATUS_INDEX  = 12'h095;
  localparam logic [11:0] MASK_INDEX    = 12'h096;
  localparam logic [11:0] CTRL_ADDR     = {CTRL_INDEX[9:0], 2'h0};
  localparam logic [11:0] RESTART_ADDR  = {RESTART_INDEX[9:0], 2'h0};
  localparam logic [11:0] STATUS_ADDR   = {STATUS_INDEX[9:0], 2'h0};
  localparam logic [11:0] MASK_ADDR     = {MASK_INDEX[9:0], 2'h0};

  ////////////////////////////////////////////////////////////////////////////
  // Control register fields
  localparam int unsigned EN_BIT       = 7;
  localparam int unsigned NMI_SEL_BIT  = 6;
  localparam int unsigned RST_FLAG_BIT = 5;
  localparam int unsigned CLK_SEL_LSB  = 3;
  localparam int unsigned PERIOD_LSB   = 0;
  localparam logic [1:0]  CLK_SYS      = 2'h0;
  localparam logic [1:0]  CLK_RTC      = 2'h1;
  localparam logic [1:0]  PERIOD_27    = 2'h0;
  localparam logic [1:0]  PERIOD_25    = 2'h1;
  localparam logic [1:0]  PERIOD_22    = 2'h2;
  localparam logic [1:0]  PERIOD_18    = 2'h3;

  ////////////////////////////////////////////////////////////////////////////
  // Restart unlock values
  localparam logic [7:0] UNLOCK_FIRST  = 8'hA5;
  localparam logic [7:0] UNLOCK_SECOND = 8'h5A;

  ////////////////////////////////////////////////////////////////////////////
  // Event status and mask layout
  localparam int unsigned STATUS_W    = 4;
  localparam int unsigned EV_TIMEOUT  = 0;
  localparam int unsigned EV_NMI      = 1;
  localparam int unsigned EV_RESTART  = 2;
  localparam int unsigned EV_BADSEQ   = 3;

  ////////////////////////////////////////////////////////////////////////////
  // Reset values and counts
  localparam logic [STATUS_W-1:0] STATUS_RESET = 4'h0;
  localparam logic [STATUS_W-1:0] MASK_RESET   = 4'h0;
  localparam int unsigned CNT_W             = 28;
  localparam int unsigned PERIOD27_CYCLES   = 134217728;
  localparam int unsigned PERIOD25_CYCLES   = 33554432;
  localparam int unsigned PERIOD22_CYCLES   = 4194304;
  localparam int unsigned PERIOD18_CYCLES   = 262144;
  localparam int unsigned RESET_HOLD_CYCLES = 16;

  ////////////////////////////////////////////////////////////////////////////
  // Types
  typedef struct packed {
    logic       enable;
    logic       nmi_sel;
    logic [1:0] clk_sel;
    logic [1:0] period_sel;
  } wtu_ctrl_t;

  localparam wtu_ctrl_t CTRL_RESET = '{1'b0, 1'b0, 2'h0, 2'h0};

  typedef enum logic [1:0] {
    WTU_OFF,
    WTU_RUN,
    WTU_HOLD
  } wtu_state_t;

endpackage : wtu_pkg

`default_nettype wire

// ==== verilog/wtu_sync.sv ====
// Two-flop synchroniser for levels arriving from outside the pclk domain
`timescale 1ns/1ps
`default_nettype none

module wtu_sync #(
  parameter int unsigned WIDTH = 1
) (
  // Clock and reset
  input  wire logic             pclk,
  input  wire logic             presetn,
  // Levels
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] stage1;

  initial begin
    if (WIDTH < 1) begin
      $error("wtu_sync: WIDTH must be at least 1");
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stage1   <= '0;
      sync_out <= '0;
    end else begin
      stage1   <= async_in;
      sync_out <= stage1;
    end
  end

endmodule : wtu_sync

`default_nettype wire

// ==== verilog/wtu_unlock.sv ====
// Detector for the two-write restart unlock sequence
`timescale 1ns/1ps
`default_nettype none

module wtu_unlock (
  // Clock and reset
  input  wire logic       pclk,
  input  wire logic       presetn,
  // Restart register writes
  input  wire logic       wr_strobe,
  input  wire logic [7:0] wr_byte,
  input  wire logic       abandon,
  // Results
  output logic            restart,
  output logic            bad_seq,
  output logic            armed
);

  // Any first value starts afresh, so a repeated first value stays armed
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      armed <= 1'b0;
    end else if (abandon) begin
      armed <= 1'b0;
    end else if (wr_strobe) begin
      armed <= (wr_byte == wtu_pkg::UNLOCK_FIRST);
    end
  end

  always_comb begin
    restart = wr_strobe && !abandon && armed &&
              (wr_byte == wtu_pkg::UNLOCK_SECOND);
    bad_seq = wr_strobe && !abandon && !restart &&
              (wr_byte != wtu_pkg::UNLOCK_FIRST);
  end

endmodule : wtu_unlock

`default_nettype wire

// ==== verilog/wtu_top.sv ====
// Watchdog timer: APB registers, down counter, reset and NMI response
//
// Contract
// - Disabled after any reset; counting starts when enable bit 7 written one.
// - Once enabled, writing zero to enable does nothing; only reset clears.
// - Period field 1:0 picks 2^27, 2^25, 2^22 or 2^18 cycles.
// - Clock field 4:3: 00 system clock, 01 real-time source; others reserved.
// - Every time-out sets reset-source flag bit 5, whatever the response.
// - Flag read-only; own reset keeps it; chip or debug-port reset clears.
// - Bit 6 zero: time-out resets device; one: time-out raises NMI.
// - Time-out outputs change level only on a rising clock edge.
// - Write A5h then 5Ah to restart register reloads counter, keeps counting.
// - Any gap allowed between unlock writes; a time-out in between voids it.
// - Restart register is 8-bit write-only, used only to detect unlock.
// - An NMI time-out sets a pollable flag naming the watchdog as cause.
//
// The implementer's own choice: the APB slave port, the other event status bits, the mask and the interrupt.
`timescale 1ns/1ps
`default_nettype none

module wtu_top #(
  parameter int unsigned PERIOD27_CYCLES = wtu_pkg::PERIOD27_CYCLES,
  parameter int unsigned PERIOD25_CYCLES = wtu_pkg::PERIOD25_CYCLES,
  parameter int unsigned PERIOD22_CYCLES = wtu_pkg::PERIOD22_CYCLES,
  parameter int unsigned PERIOD18_CYCLES = wtu_pkg::PERIOD18_CYCLES,
  parameter int unsigned RESET_HOLD      = wtu_pkg::RESET_HOLD_CYCLES
) (
  // Clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // APB slave
  input  wire logic [11:0] paddr,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // Asynchronous inputs
  input  wire logic        rtc_clk_src,
  input  wire logic        debug_reset_req,
  // Time-out responses and interrupt
  output logic             wdt_reset_out,
  output logic             nmi_out,
  output logic             irq
);

  ////////////////////////////////////////////////////////////////////////////
  // Elaboration checks
  localparam int unsigned CW = wtu_pkg::CNT_W;

  initial begin
    if (PERIOD27_CYCLES < 2 || PERIOD27_CYCLES >= (1 << CW) ||
        PERIOD25_CYCLES < 2 || PERIOD25_CYCLES >= (1 << CW) ||
        PERIOD22_CYCLES < 2 || PERIOD22_CYCLES >= (1 << CW) ||
        PERIOD18_CYCLES < 2 || PERIOD18_CYCLES >= (1 << CW)) begin
      $error("wtu_top: period counts must lie in 2 .. 2^CNT_W-1");
    end
    if (RESET_HOLD < 1 || RESET_HOLD > 255) begin
      $error("wtu_top: RESET_HOLD must lie in 1 .. 255");
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Declarations
  wtu_pkg::wtu_ctrl_t            ctrl;
  wtu_pkg::wtu_state_t           state;
  logic                          rst_flag;
  logic [wtu_pkg::STATUS_W-1:0]  status;
  logic [wtu_pkg::STATUS_W-1:0]  mask;
  logic [wtu_pkg::STATUS_W-1:0]  events;
  logic [CW-1:0]                 count;
  logic [CW-1:0]                 reload_value;
  logic [7:0]                    hold_count;
  logic                          rtc_sync;
  logic                          rtc_prev;
  logic                          dbg_sync;
  logic                          tick;
  logic                          timeout;
  logic                          self_reset;
  logic                          setup;
  logic                          access;
  logic                          wr_low;
  logic                          hit_ctrl;
  logic                          hit_restart;
  logic                          hit_status;
  logic                          hit_mask;
  logic                          mapped;
  logic                          restart_wr;
  logic                          restart;
  logic                          bad_seq;
  logic                          armed;
  logic [31:0]                   next_prdata;

  ////////////////////////////////////////////////////////////////////////////
  // Synchronisers for the real-time source and the debug-port reset
  wtu_sync #(
    .WIDTH    (2)
  ) u_sync (
    .pclk     (pclk),
    .presetn  (presetn),
    .async_in ({debug_reset_req, rtc_clk_src}),
    .sync_out ({dbg_sync, rtc_sync})
  );

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rtc_prev <= 1'b0;
    end else begin
      rtc_prev <= rtc_sync;
    end
  end

  // Counting tick; reserved clock codes hold the count still
  always_comb begin
    case (ctrl.clk_sel)
      wtu_pkg::CLK_SYS: tick = 1'b1;
      wtu_pkg::CLK_RTC: tick = rtc_prev && !rtc_sync;
      default:          tick = 1'b0;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // APB decode
  always_comb begin
    setup       = psel && !penable;
    access      = psel && penable;
    wr_low      = access && pwrite && pstrb[0];
    hit_ctrl    = 1'b0;
    hit_restart = 1'b0;
    hit_status  = 1'b0;
    hit_mask    = 1'b0;
    if (paddr == wtu_pkg::CTRL_ADDR) begin
      hit_ctrl = 1'b1;
    end else if (paddr == wtu_pkg::RESTART_ADDR) begin
      hit_restart = 1'b1;
    end else if (paddr == wtu_pkg::STATUS_ADDR) begin
      hit_status = 1'b1;
    end else if (paddr == wtu_pkg::MASK_ADDR) begin
      hit_mask = 1'b1;
    end
    mapped     = hit_ctrl || hit_restart || hit_status || hit_mask;
    restart_wr = wr_low && hit_restart;
  end

  // Zero-wait slave; unmapped addresses answer with an error
  assign pready  = 1'b1;
  assign pslverr = access && !mapped;

  // Read data captured in the setup cycle so it comes from a flop
  always_comb begin
    next_prdata = 32'h0000_0000;
    if (hit_ctrl) begin
      next_prdata[wtu_pkg::EN_BIT]      = ctrl.enable;
      next_prdata[wtu_pkg::NMI_SEL_BIT] = ctrl.nmi_sel;
      next_prdata[wtu_pkg::RST_FLAG_BIT] = rst_flag;
      next_prdata[wtu_pkg::CLK_SEL_LSB +: 2] = ctrl.clk_sel;
      next_prdata[wtu_pkg::PERIOD_LSB +: 2]  = ctrl.period_sel;
    end else if (hit_status) begin
      next_prdata[wtu_pkg::STATUS_W-1:0] = status;
    end else if (hit_mask) begin
      next_prdata[wtu_pkg::STATUS_W-1:0] = mask;
    end
    // Restart register has no readable content: reads give zero
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (setup && !pwrite) begin
      prdata <= next_prdata;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Unlock sequence
  wtu_unlock u_unlock (
    .pclk      (pclk),
    .presetn   (presetn),
    .wr_strobe (restart_wr),
    .wr_byte   (pwdata[7:0]),
    .abandon   (timeout || self_reset || dbg_sync),
    .restart   (restart),
    .bad_seq   (bad_seq),
    .armed     (armed)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Control register
  // Own reset re-initialises control, counter and unlock; cause flag, status and mask are kept
  assign self_reset = (state == wtu_pkg::WTU_HOLD) &&
                      (hold_count == 8'h01);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl <= wtu_pkg::CTRL_RESET;
    end else if (dbg_sync || self_reset) begin
      ctrl <= wtu_pkg::CTRL_RESET;
    end else if (wr_low && hit_ctrl) begin
      ctrl.enable     <= ctrl.enable | pwdata[wtu_pkg::EN_BIT];
      ctrl.nmi_sel    <= pwdata[wtu_pkg::NMI_SEL_BIT];
      ctrl.clk_sel    <= pwdata[wtu_pkg::CLK_SEL_LSB +: 2];
      ctrl.period_sel <= pwdata[wtu_pkg::PERIOD_LSB +: 2];
    end
  end

  // Cause flag: cleared only by chip or debug-port reset
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rst_flag <= 1'b0;
    end else if (timeout) begin
      rst_flag <= 1'b1;
    end else if (dbg_sync) begin
      rst_flag <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Counter and sequencing
  always_comb begin
    case (ctrl.period_sel)
      wtu_pkg::PERIOD_27: reload_value = CW'(PERIOD27_CYCLES);
      wtu_pkg::PERIOD_25: reload_value = CW'(PERIOD25_CYCLES);
      wtu_pkg::PERIOD_22: reload_value = CW'(PERIOD22_CYCLES);
      default:            reload_value = CW'(PERIOD18_CYCLES);
    endcase
  end

  assign timeout = (state == wtu_pkg::WTU_RUN) && tick &&
                   (count == CW'(1));

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= wtu_pkg::WTU_OFF;
    end else if (dbg_sync) begin
      state <= wtu_pkg::WTU_OFF;
    end else begin
      case (state)
        wtu_pkg::WTU_OFF: begin
          if (ctrl.enable) begin
            state <= wtu_pkg::WTU_RUN;
          end
        end
        wtu_pkg::WTU_RUN: begin
          if (timeout && !ctrl.nmi_sel) begin
            state <= wtu_pkg::WTU_HOLD;
          end
        end
        wtu_pkg::WTU_HOLD: begin
          if (self_reset) begin
            state <= wtu_pkg::WTU_OFF;
          end
        end
        default: state <= wtu_pkg::WTU_OFF;
      endcase
    end
  end

  // Restart reloads; NMI mode reloads on time-out and keeps running
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count <= '0;
    end else if (state != wtu_pkg::WTU_RUN) begin
      count <= reload_value;
    end else if (restart) begin
      count <= reload_value;
    end else if (timeout) begin
      count <= reload_value;
    end else if (tick) begin
      count <= count - CW'(1);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hold_count <= 8'h00;
    end else if (timeout && !ctrl.nmi_sel) begin
      hold_count <= 8'(RESET_HOLD);
    end else if (state == wtu_pkg::WTU_HOLD) begin
      hold_count <= hold_count - 8'h01;
    end
  end

  // Registered responses: levels move only at the rising edge
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wdt_reset_out <= 1'b0;
      nmi_out       <= 1'b0;
    end else begin
      wdt_reset_out <= (timeout && !ctrl.nmi_sel) ||
                       ((state == wtu_pkg::WTU_HOLD) && !self_reset);
      nmi_out       <= timeout && ctrl.nmi_sel;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Event status, mask and interrupt
  always_comb begin
    events = '0;
    events[wtu_pkg::EV_TIMEOUT] = timeout;
    events[wtu_pkg::EV_NMI]     = timeout && ctrl.nmi_sel;
    events[wtu_pkg::EV_RESTART] = restart && (state == wtu_pkg::WTU_RUN);
    events[wtu_pkg::EV_BADSEQ]  = bad_seq;
  end

  // Set wins over a write-one clear in the same cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      status <= wtu_pkg::STATUS_RESET;
    end else if (dbg_sync) begin
      status <= wtu_pkg::STATUS_RESET;
    end else if (wr_low && hit_status) begin
      status <= (status & ~pwdata[wtu_pkg::STATUS_W-1:0]) | events;
    end else begin
      status <= status | events;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mask <= wtu_pkg::MASK_RESET;
    end else if (wr_low && hit_mask) begin
      mask <= pwdata[wtu_pkg::STATUS_W-1:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq <= 1'b0;
    end else begin
      irq <= |(status & mask);
    end
  end

endmodule : wtu_top

`default_nettype wire

// ==== test/wtu_top_properties.sv ====
// Checker: port-level properties of the watchdog timer
`timescale 1ns/1ps
`default_nettype none

module wtu_top_properties #(
  parameter int unsigned PERIOD18_CYCLES = 8,
  parameter int unsigned RESET_HOLD      = 16
) (
  // Clock and reset
  input wire logic        pclk,
  input wire logic        presetn,
  // APB
  input wire logic [11:0] paddr,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [31:0] pwdata,
  input wire logic [3:0]  pstrb,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  // Responses
  input wire logic        wdt_reset_out,
  input wire logic        nmi_out
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  logic [7:0]  hold_cnt;
  logic [31:0] en_age;
  logic        mapped;

  assign mapped = paddr inside {wtu_pkg::CTRL_ADDR, wtu_pkg::RESTART_ADDR,
                                wtu_pkg::STATUS_ADDR, wtu_pkg::MASK_ADDR};

  ////////////////////
  // Age of the enable write; bounds how soon a time-out may come
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) en_age <= '0;
    else if (en_age != 0) en_age <= en_age + 32'h1;
    else if (psel && penable && pwrite && pstrb[0] && pwdata[7] &&
             paddr == wtu_pkg::CTRL_ADDR) en_age <= 32'h1;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) hold_cnt <= '0;
    else if (wdt_reset_out) hold_cnt <= hold_cnt + 8'h01;
    else hold_cnt <= '0;
  end

  ////////////////////
  sequence acc_s;
    psel && penable;
  endsequence
  sequence rd_restart_s;
    acc_s ##0 (!pwrite && paddr == wtu_pkg::RESTART_ADDR);
  endsequence
  sequence rd_ctrl_s;
    acc_s ##0 (!pwrite && paddr == wtu_pkg::CTRL_ADDR);
  endsequence

  a_no_early_timeout: assert property (
    (nmi_out || $rose(wdt_reset_out)) |-> en_age >= PERIOD18_CYCLES)
    else $error("time-out before the shortest period");
  a_nmi_one_pulse: assert property (nmi_out |=> !nmi_out)
    else $error("nmi_out longer than one cycle");
  a_resp_exclusive: assert property (!(nmi_out && wdt_reset_out))
    else $error("reset and nmi together");
  a_hold_bound: assert property (wdt_reset_out |-> hold_cnt < RESET_HOLD)
    else $error("reset output held too long");
  a_hold_exact_length: assert property (
    $fell(wdt_reset_out) |-> $past(hold_cnt) == RESET_HOLD - 1)
    else $error("reset output held too short");
  a_restart_reads_zero: assert property (rd_restart_s |-> prdata == 0)
    else $error("restart register read not zero");
  a_ctrl_spare_zero: assert property (
    rd_ctrl_s |-> prdata[31:8] == 0 && !prdata[2])
    else $error("control spare bits not zero");
  a_unmapped_error: assert property (
    acc_s ##0 !mapped |-> pslverr && (pwrite || prdata == 0))
    else $error("unmapped access not refused");
  a_mapped_no_error: assert property (acc_s ##0 mapped |-> !pslverr)
    else $error("mapped access refused");
  a_idle_no_error: assert property (!(psel && penable) |-> !pslverr)
    else $error("pslverr outside access");
  a_ready_high: assert property (psel |-> pready)
    else $error("pready low");
endmodule : wtu_top_properties

bind wtu_top wtu_top_properties #(
  .PERIOD18_CYCLES(PERIOD18_CYCLES), .RESET_HOLD(RESET_HOLD)
) wtu_top_properties_inst (
  .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
  .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .pstrb(pstrb),
  .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .wdt_reset_out(wdt_reset_out), .nmi_out(nmi_out)
);

`default_nettype wire

// ==== test/test_wtu_top.sv ====
// Testbench: register-level checks of the watchdog timer
`timescale 1ns/1ps
`default_nettype none

module test_wtu_top;
  localparam int PER [4] = '{64, 32, 16, 8};
  logic        pclk = 1'b0;
  logic        presetn = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [31:0] pwdata = 32'h0;
  logic [3:0]  pstrb = 4'hF;
  logic        rtc_clk_src = 1'b0;
  logic        debug_reset_req = 1'b0;
  logic        rtc_run = 1'b0;
  logic [2:0]  rdiv = 3'h0;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        wdt_reset_out;
  logic        nmi_out;
  logic        irq;
  logic [31:0] rd;
  logic        er;
  int          n;
  int          err_total = 0;
  int          checked = 0;

  always #5 pclk = ~pclk;

  wtu_top #(.PERIOD27_CYCLES(64), .PERIOD25_CYCLES(32),
    .PERIOD22_CYCLES(16), .PERIOD18_CYCLES(8), .RESET_HOLD(4)
  ) wtu_top_inst (
    .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .pstrb(pstrb),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .rtc_clk_src(rtc_clk_src), .debug_reset_req(debug_reset_req),
    .wdt_reset_out(wdt_reset_out), .nmi_out(nmi_out), .irq(irq)
  );

  // Slow source toggles every 8 pclk, and stands still when not wanted
  always @(posedge pclk) begin
    rdiv <= rdiv + 3'h1;
    if (rtc_run && rdiv == 3'h7) rtc_clk_src <= ~rtc_clk_src;
  end

  ////////////////////
  task automatic print_verdict;
    $display("comparisons %0d mismatches %0d", checked, err_total);
    if (err_total == 0 && checked > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : print_verdict

  task automatic chk(input string name, input logic [31:0] exp,
                     input logic [31:0] got);
    checked++;
    if (got !== exp) begin
      err_total++;
      $display("MISMATCH %s expected %0h seen %0h", name, exp, got);
    end
  endtask : chk

  task automatic chk_rng(input string name, input int lo, input int hi,
                         input int got);
    checked++;
    if (got < lo || got > hi) begin
      err_total++;
      $display("MISMATCH %s expected %0d..%0d seen %0d", name, lo, hi, got);
    end
  endtask : chk_rng

  // One APB transfer; starts one edge late so releases never collide
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [7:0] d);
    int k;
    k = 0;
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= {24'h0, d};
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1 && k < 20) begin
      k++;
      @(posedge pclk);
    end
    rd = prdata;
    er = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    if (k == 20) begin
      err_total++;
      print_verdict;
    end
  endtask : apb

  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    apb(1'b1, a, d);
  endtask : wr

  task automatic rdc(input logic [11:0] a, input logic [7:0] e,
                     input string name);
    apb(1'b0, a, 8'h00);
    chk(name, {24'h0, e}, rd);
  endtask : rdc

  task automatic wait_out(input logic which, input int lim);
    n = 0;
    while ((which ? wdt_reset_out : nmi_out) !== 1'b1 && n < lim) begin
      @(posedge pclk);
      n++;
    end
  endtask : wait_out

  task automatic chip_reset;
    presetn <= 1'b0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
  endtask : chip_reset

  ////////////////////
  initial begin
    @(posedge pclk);
    chip_reset;
    rdc(wtu_pkg::CTRL_ADDR, 8'h00, "ctrl");
    rdc(wtu_pkg::STATUS_ADDR, 8'h00, "status");
    rdc(wtu_pkg::MASK_ADDR, 8'h00, "mask");
    rdc(wtu_pkg::RESTART_ADDR, 8'h00, "restart");
    apb(1'b0, 12'hFF0, 8'h00);
    chk("unmapped err", 32'h1, {31'h0, er});
    chk("unmapped data", 32'h0, rd);
    pstrb <= 4'hE;
    wr(wtu_pkg::MASK_ADDR, 8'h0F);
    pstrb <= 4'hF;
    rdc(wtu_pkg::MASK_ADDR, 8'h00, "mask strobe");
    $display("test reset_values done");
    for (int i = 0; i < 4; i++) begin
      chip_reset;
      rdc(wtu_pkg::CTRL_ADDR, 8'h00, "ctrl after reset");
      wr(wtu_pkg::CTRL_ADDR, 8'hC0 | 8'(i));
      wait_out(1'b0, 200);
      chk_rng("nmi delay", PER[i], PER[i] + 4, n);
    end
    wr(wtu_pkg::CTRL_ADDR, 8'h43);
    rdc(wtu_pkg::CTRL_ADDR, 8'hE3, "ctrl sticky");
    rdc(wtu_pkg::STATUS_ADDR, 8'h03, "status nmi");
    $display("test periods done");
    chip_reset;
    wr(wtu_pkg::CTRL_ADDR, 8'hC0);
    repeat (20) @(posedge pclk);
    wr(wtu_pkg::RESTART_ADDR, 8'hA5);
    repeat (20) @(posedge pclk);
    wr(wtu_pkg::RESTART_ADDR, 8'h5A);
    wait_out(1'b0, 200);
    chk_rng("restart delay", 64, 68, n);
    wr(wtu_pkg::RESTART_ADDR, 8'hA5);
    wr(wtu_pkg::RESTART_ADDR, 8'h33);
    wr(wtu_pkg::RESTART_ADDR, 8'h5A);
    wait_out(1'b0, 200);
    chk_rng("no restart", 50, 58, n);
    rdc(wtu_pkg::STATUS_ADDR, 8'h0F, "status seq");
    chk("irq masked", 32'h0, {31'h0, irq});
    wr(wtu_pkg::MASK_ADDR, 8'h08);
    repeat (2) @(posedge pclk);
    chk("irq raised", 32'h1, {31'h0, irq});
    wr(wtu_pkg::STATUS_ADDR, 8'h08);
    repeat (2) @(posedge pclk);
    chk("irq cleared", 32'h0, {31'h0, irq});
    wait_out(1'b0, 200);
    wr(wtu_pkg::RESTART_ADDR, 8'hA5);
    wait_out(1'b0, 200);
    wr(wtu_pkg::RESTART_ADDR, 8'h5A);
    wait_out(1'b0, 200);
    chk_rng("voided unlock", 58, 62, n);
    chk("irq bad seq", 32'h1, {31'h0, irq});
    $display("test restart done");
    chip_reset;
    wr(wtu_pkg::CTRL_ADDR, 8'hD3);
    wait_out(1'b0, 40);
    chk("reserved clock", 32'd40, n);
    wr(wtu_pkg::CTRL_ADDR, 8'hCB);
    wait_out(1'b0, 40);
    chk("rtc idle", 32'd40, n);
    rtc_run <= 1'b1;
    wait_out(1'b0, 300);
    rtc_run <= 1'b0;
    chk_rng("rtc delay", 100, 160, n);
    $display("test clock_select done");
    chip_reset;
    wr(wtu_pkg::CTRL_ADDR, 8'h83);
    wait_out(1'b1, 40);
    chk_rng("reset delay", 8, 12, n);
    repeat (8) @(posedge pclk);
    rdc(wtu_pkg::CTRL_ADDR, 8'h20, "flag kept");
    rdc(wtu_pkg::STATUS_ADDR, 8'h01, "status rst");
    debug_reset_req <= 1'b1;
    repeat (6) @(posedge pclk);
    debug_reset_req <= 1'b0;
    repeat (4) @(posedge pclk);
    rdc(wtu_pkg::CTRL_ADDR, 8'h00, "debug reset");
    $display("test reset_mode done");
    print_verdict;
  end
endmodule : test_wtu_top

`default_nettype wire
